// file: design/ctd_pkg.sv
// Package for the converter trim and delay register bank.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package ctd_pkg;
  // Printed register indexes; byte address is four times the index
  localparam logic [3:0] CTD_IDX_FSR = 4'hB;
  localparam logic [3:0] CTD_IDX_COARSE = 4'hC;
  localparam logic [3:0] CTD_IDX_FINE = 4'hD;
  localparam logic [11:0] CTD_ADDR_FSR = {6'h00, CTD_IDX_FSR, 2'h0};
  localparam logic [11:0] CTD_ADDR_COARSE = {6'h00, CTD_IDX_COARSE, 2'h0};
  localparam logic [11:0] CTD_ADDR_FINE = {6'h00, CTD_IDX_FINE, 2'h0};
  // Values after reset
  localparam logic [15:0] CTD_RST_FSR = 16'h4000;
  localparam logic [15:0] CTD_RST_COARSE = 16'h0004;
  localparam logic [15:0] CTD_RST_FINE = 16'h0000;
  // Full-scale magnitude field and its usable range
  localparam int CTD_FSR_MSB = 14;
  localparam logic [14:0] CTD_FSR_MIN = 15'h4000;
  localparam logic [14:0] CTD_FSR_MAX = 15'h7FFF;
  // Coarse register field positions
  localparam int CTD_CRS_LSB = 4;
  localparam int CTD_ENA_BIT = 3;
  localparam int CTD_DCS_BIT = 2;
  // Coarse code at which the delay saturates
  localparam logic [11:0] CTD_CRS_SAT = 12'h97F;
  // Fine code field position
  localparam int CTD_FINE_LSB = 10;
endpackage

// file: design/ctd_regs.sv
// Register bank for full-scale trim and aperture delay, APB slave.
// Assumes APB3 signalling on ref_clk; drives decoded trim outputs.
// Assumes all bus inputs are synchronous to ref_clk.
// Assumes software keeps the mode and clock-rate limits of the delay feature;
// the bank neither knows the sampling mode nor the sampling clock rate.
// Every trim output is registered, so it follows its register one cycle late.
//
// Register access over APB was chosen for this implementation.

module ctd_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [14:0] full_scale_magnitude,
  output logic [11:0] coarse_delay_code,
  output logic [5:0] fine_delay_code,
  output logic delay_adjust_enable,
  output logic duty_cycle_stabiliser_enable,
  output logic delay_saturated
);
  import ctd_pkg::*;

  // Reset synchroniser stages
  logic rst_meta_r;
  logic rst_sync_r;
  // Stored register words
  logic [15:0] fsr_q;
  logic [15:0] crs_q;
  logic [15:0] fine_q;
  // Decoded access strobes
  logic setup_ok;
  logic wr_fsr;
  logic wr_crs;
  logic wr_fine;
  logic addr_hit;
  logic [15:0] rd_nxt;
  logic [11:0] crs_eff;

  // Release reset through two flip-flops
  // Assertion of rstn acts at once; release is retimed so that no
  // register leaves reset on a different edge from its neighbours.
  // Nothing but the second stage reads the first one.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Access phase ends each transfer in one cycle
  // A write is taken only at the edge where pready is sampled high,
  // so a master that stretches its access phase cannot write twice.
  assign setup_ok = psel && penable && pready;
  // Unmapped addresses answer with an error
  assign addr_hit = (paddr == CTD_ADDR_FSR) || (paddr == CTD_ADDR_COARSE) || (paddr == CTD_ADDR_FINE);
  assign wr_fsr = setup_ok && pwrite && (paddr == CTD_ADDR_FSR);
  assign wr_crs = setup_ok && pwrite && (paddr == CTD_ADDR_COARSE);
  assign wr_fine = setup_ok && pwrite && (paddr == CTD_ADDR_FINE);

  // Reserved bit 15 held at zero
  ctd_word_reg #(.RESET_VAL(CTD_RST_FSR), .WR_MASK(16'h7FFF)) u_fsr (
    .clk(ref_clk),
    .rst_n(rst_sync_r),
    .wr_en(wr_fsr),
    .wr_data(pwdata[15:0]),
    .q(fsr_q)
  );
  // Coarse word, stabiliser bit resets to one
  ctd_word_reg #(.RESET_VAL(CTD_RST_COARSE), .WR_MASK(16'hFFFC)) u_crs (
    .clk(ref_clk),
    .rst_n(rst_sync_r),
    .wr_en(wr_crs),
    .wr_data(pwdata[15:0]),
    .q(crs_q)
  );
  // Fine word storage, reserved low bits kept zero
  ctd_word_reg #(.RESET_VAL(CTD_RST_FINE), .WR_MASK(16'hFC00)) u_fine (
    .clk(ref_clk),
    .rst_n(rst_sync_r),
    .wr_en(wr_fine),
    .wr_data(pwdata[15:0]),
    .q(fine_q)
  );

  // Read multiplexer
  // Unmapped addresses fall through to zero, which the bus then returns
  // together with an error flag.
  always_comb begin
    rd_nxt = 16'h0000;
    if (paddr == CTD_ADDR_FSR) begin
      rd_nxt = fsr_q;
    end else if (paddr == CTD_ADDR_COARSE) begin
      rd_nxt = crs_q;
    end else if (paddr == CTD_ADDR_FINE) begin
      rd_nxt = fine_q;
    end
  end

  // APB answer: ready during access phase, one wait-free cycle
  // The answer is prepared in the setup cycle, so pready, pslverr and
  // prdata all stand in the access cycle only and fall back afterwards.
  // Read data is zero outside a read answer, which keeps the bus quiet.
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_hit;
      prdata <= (psel && !penable && !pwrite) ? {16'h0000, rd_nxt} : 32'h0000_0000;
    end
  end

  // Saturate coarse code at the maximum delay
  // Codes above the saturation point give the same delay as the
  // saturation code itself, so the output never shows them.
  assign crs_eff = (crs_q[15:CTD_CRS_LSB] > CTD_CRS_SAT) ? CTD_CRS_SAT : crs_q[15:CTD_CRS_LSB];

  // Drive trim outputs from flip-flops
  // Outputs are retimed so the analog side sees glitch-free codes.
  // A full-scale code below the usable range is kept in the register
  // for read-back, but the output is held at the lowest usable code.
  always_ff @(posedge ref_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      full_scale_magnitude <= CTD_RST_FSR[CTD_FSR_MSB:0];
      coarse_delay_code <= 12'h000;
      fine_delay_code <= 6'h00;
      delay_adjust_enable <= 1'b0;
      duty_cycle_stabiliser_enable <= 1'b1;
      delay_saturated <= 1'b0;
    end else begin
      // Full-scale magnitude clamped to usable range
      full_scale_magnitude <= (fsr_q[CTD_FSR_MSB:0] < CTD_FSR_MIN) ? CTD_FSR_MIN : fsr_q[CTD_FSR_MSB:0];
      // Codes reach the clock only when enabled
      // Fine code gated by the enable
      coarse_delay_code <= crs_q[CTD_ENA_BIT] ? crs_eff : 12'h000;
      fine_delay_code <= crs_q[CTD_ENA_BIT] ? fine_q[15:CTD_FINE_LSB] : 6'h00;
      delay_adjust_enable <= crs_q[CTD_ENA_BIT];
      duty_cycle_stabiliser_enable <= crs_q[CTD_DCS_BIT];
      delay_saturated <= crs_q[CTD_ENA_BIT] && (crs_q[15:CTD_CRS_LSB] >= CTD_CRS_SAT);
    end
  end

  // Assertions

  // Write lands in coarse register
  a_crs_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    wr_crs |=> crs_q == ($past(pwdata[15:0]) & 16'hFFFC)) else $error("coarse write lost");

  // Write lands in full-scale register
  a_fsr_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    wr_fsr |=> fsr_q == ($past(pwdata[15:0]) & 16'h7FFF)) else $error("full-scale write lost");

  // Write lands in fine register
  a_fine_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    wr_fine |=> fine_q == ($past(pwdata[15:0]) & 16'hFC00)) else $error("fine write lost");

  // Full-scale word holds without a write
  a_fsr_holds: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !wr_fsr |=> $stable(fsr_q)) else $error("full-scale word changed");

  // Coarse word holds without a write
  a_crs_holds: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !wr_crs |=> $stable(crs_q)) else $error("coarse word changed");

  // Fine word holds without a write
  a_fine_holds: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !wr_fine |=> $stable(fine_q)) else $error("fine word changed");

  // Reserved full-scale bit stays zero
  a_fsr_res_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !fsr_q[15]) else $error("full-scale reserved bit set");

  // Reserved coarse bits stay zero
  a_crs_res_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    crs_q[1:0] == 2'b00) else $error("coarse reserved bits set");

  // Reserved fine bits stay zero
  a_fine_res_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    fine_q[9:0] == 10'h000) else $error("fine reserved bits set");

  // Full-scale output never below range
  a_fsr_range: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    ##1 full_scale_magnitude >= CTD_FSR_MIN) else $error("full-scale below range");

  // Usable full-scale code passes unchanged
  a_fsr_passes: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    fsr_q[14:0] >= CTD_FSR_MIN |=> full_scale_magnitude == $past(fsr_q[14:0]))
    else $error("full-scale code altered");

  // Low full-scale code gives the lowest range
  a_fsr_clamps: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    fsr_q[14:0] < CTD_FSR_MIN |=> full_scale_magnitude == CTD_FSR_MIN) else $error("full-scale not clamped");

  // Codes at or above saturation give the maximum
  a_crs_saturate: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    crs_q[CTD_ENA_BIT] && crs_q[15:4] >= CTD_CRS_SAT |=> coarse_delay_code == CTD_CRS_SAT)
    else $error("coarse code not saturated");

  // Codes below saturation pass unchanged
  a_crs_linear: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    crs_q[CTD_ENA_BIT] && crs_q[15:4] < CTD_CRS_SAT |=> coarse_delay_code == $past(crs_q[15:4]))
    else $error("coarse code altered");

  // Saturation flag rises with a saturating code
  a_sat_set: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    crs_q[CTD_ENA_BIT] && crs_q[15:4] >= CTD_CRS_SAT |=> delay_saturated) else $error("saturation flag missing");

  // Saturation flag never without the enable
  a_sat_needs_ena: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    delay_saturated |-> delay_adjust_enable) else $error("saturation flag while off");

  // Coarse code silent while disabled
  a_ena_gates: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !crs_q[CTD_ENA_BIT] |=> coarse_delay_code == 12'h000) else $error("coarse active while off");

  // Enable output follows its bit
  a_ena_follow: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    ##1 delay_adjust_enable == $past(crs_q[CTD_ENA_BIT])) else $error("enable output wrong");

  // Fine code follows its field while enabled
  a_fine_gates: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    crs_q[CTD_ENA_BIT] |=> fine_delay_code == $past(fine_q[15:10])) else $error("fine code wrong");

  // Fine code silent while disabled
  a_fine_off: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !crs_q[CTD_ENA_BIT] |=> fine_delay_code == 6'h00) else $error("fine active while off");

  // Stabiliser follows the written bit
  a_dcs_follow: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    wr_crs ##1 1'b1 |=> duty_cycle_stabiliser_enable == $past(pwdata[2], 2)) else $error("stabiliser wrong");

  // Stabiliser output tracks the stored bit
  a_dcs_track: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    ##1 duty_cycle_stabiliser_enable == $past(crs_q[CTD_DCS_BIT])) else $error("stabiliser output wrong");

  // Fine register reads back
  a_read_back: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable && !pwrite && paddr == CTD_ADDR_FINE |=> prdata[15:0] == fine_q)
    else $error("fine read back wrong");

  // Full-scale register reads back
  a_read_fsr: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable && !pwrite && paddr == CTD_ADDR_FSR |=> prdata == {16'h0000, fsr_q})
    else $error("full-scale read back wrong");

  // Coarse register reads back
  a_read_crs: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable && !pwrite && paddr == CTD_ADDR_COARSE |=> prdata == {16'h0000, crs_q})
    else $error("coarse read back wrong");

  // Setup cycle is answered next cycle
  a_ready_next: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable |=> pready) else $error("no answer to setup");

  // Ready stands one cycle only
  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    pready |=> !pready) else $error("ready held too long");

  // Error flag only with ready
  a_err_ready: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    pslverr |-> pready) else $error("error without ready");

  // Unmapped setup answers with an error
  a_err_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable && !addr_hit |=> pslverr) else $error("unmapped without error");

  // Mapped setup answers without an error
  a_err_mapped: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    psel && !penable && addr_hit |=> !pslverr) else $error("mapped with error");

  // Read data quiet outside an answer
  a_rdata_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    !pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");

  // Unmapped write changes no register
  a_unmapped_nowrite: assert property (@(posedge ref_clk) disable iff (!rst_sync_r)
    setup_ok && pwrite && !addr_hit |=> $stable(fsr_q) && $stable(crs_q) && $stable(fine_q))
    else $error("unmapped write stored");
endmodule

// file: design/ctd_word_reg.sv
// One 16-bit register word with a write mask of writable bits.
// Assumes the caller supplies a single-cycle write strobe.
module ctd_word_reg #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hFFFF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] q
);
  // Stored word, loads its default at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= (wr_data & WR_MASK) | (q & ~WR_MASK);
    end
  end
endmodule

// file: testbench/ctd_regs_tb.sv
// Bench for the trim and delay register bank, driven as an APB master.
// Assumes ctd_pkg constants, zero wait states and one-cycle output lag.
module ctd_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ctd_pkg::*;
  logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0; // Bench drives
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, en, dcs, dsat, ena, dce;
  logic [14:0] fsm;
  logic [11:0] crs, cd;
  logic [5:0] fd;
  logic [15:0] v, f;
  logic [32:0] q[$]; // Expected {pslverr, prdata} of each transfer, read or write
  logic [11:0] codes [4] = '{12'h000, 12'h97E, 12'h97F, 12'hFFF};
  int seed = 94, n_mismatch = 0, checks = 0, cyc = 0;
  ctd_regs dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .full_scale_magnitude(fsm), .coarse_delay_code(cd), .fine_delay_code(fd),
    .delay_adjust_enable(ena), .duty_cycle_stabiliser_enable(dce), .delay_saturated(dsat));
  // Clock of 10 ns
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare one value, count it
  task chk(input logic [32:0] seen, input logic [32:0] expv);
    checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  // Verdict and end of run
  task stop_test;
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; random upper data bits must be ignored
  task apb(input logic [11:0] a, input logic w, input logic [15:0] d, input logic [32:0] e);
    q.push_back(e);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'($random(seed)), d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  // Transfer monitor: oldest note against what the slave returned
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, q.pop_front());
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    chk({fsm, dce, ena, dsat}, {CTD_FSR_MIN, 3'b100});
    apb(CTD_ADDR_FSR, 0, 0, {17'h0, CTD_RST_FSR});
    apb(CTD_ADDR_COARSE, 0, 0, {17'h0, CTD_RST_COARSE});
    apb(CTD_ADDR_FINE, 0, 0, {17'h0, CTD_RST_FINE});
    // Magnitude: top, below range, bottom, random
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h3FFF : (i == 2) ? 16'h4000 : {1'b0, 15'($random(seed))};
      apb(CTD_ADDR_FSR, 1, v, 0);
      apb(CTD_ADDR_FSR, 0, 0, {18'h0, v[14:0]});
      chk(fsm, (v[14:0] < CTD_FSR_MIN) ? CTD_FSR_MIN : v[14:0]);
    end
    // Coarse codes around saturation, with and without enable
    for (int i = 0; i < 8; i++) begin
      crs = codes[i % 4];
      en = i / 4;
      dcs = $random(seed);
      f = $random(seed);
      apb(CTD_ADDR_COARSE, 1, {crs, en, dcs, 2'b00}, 0);
      apb(CTD_ADDR_FINE, 1, {f[15:10], 10'h0}, 0);
      apb(CTD_ADDR_COARSE, 0, 0, {17'h0, crs, en, dcs, 2'b00});
      apb(CTD_ADDR_FINE, 0, 0, {17'h0, f[15:10], 10'h0});
      chk(cd, en ? ((crs > CTD_CRS_SAT) ? CTD_CRS_SAT : crs) : 12'h000);
      chk(dsat, en && crs >= CTD_CRS_SAT);
      chk({ena, dce}, {en, dcs});
      chk(fd, en ? f[15:10] : 6'h00);
    end
    // Unmapped places refuse and read zero
    apb(12'h038, 1, 16'hFFFF, {1'b1, 32'h0});
    apb(12'h038, 0, 0, {1'b1, 32'h0});
    apb(12'h028, 0, 0, {1'b1, 32'h0});
    // Reset in mid-run brings back the defaults
    rstn <= 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
    chk({fsm, dce, ena, dsat, cd}, {CTD_FSR_MIN, 3'b100, 12'h000});
    chk(fd, 6'h00);
    apb(CTD_ADDR_COARSE, 0, 0, {17'h0, CTD_RST_COARSE});
    apb(CTD_ADDR_FSR, 0, 0, {17'h0, CTD_RST_FSR});
    repeat (2) @(posedge ref_clk);
    chk(q.size(), 0);
    stop_test;
  end
endmodule
